/* File: verilog/ltr_pkg.sv */
`default_nettype none
package ltr_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned CUR_W = 16;
  localparam int unsigned DEG_W = 8;
  localparam int unsigned LVL_W = 32;
  localparam int unsigned TC_W = 24;
  localparam int unsigned TEMP_W = 16;
  localparam int unsigned QFRAC = 16;
  localparam int unsigned RFRAC = 8;
  localparam logic [7:0] PCT_FULL = 8'h64;
  localparam int unsigned SAMPLE_RATE_HZ = 1000;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_AMBIENT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ALARM = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TRIP = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_UNLOCK = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_RATED_CUR = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_RATED_TEMP = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_BASE_TEMP = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_TIME_CONST = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STARTUP = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_LEVEL = 8'h2c;
  // Control field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_SENS_BIT = 2;
  localparam int unsigned CTRL_LOAD_BIT = 3;
  // Status field positions
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_ALARM_BIT = 1;
  localparam int unsigned STAT_TRIP_BIT = 2;
  localparam int unsigned STAT_TEMP_LSB = 16;
  // Operating modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_PULSED = 2'h1;
  localparam logic [1:0] MODE_LOCKED = 2'h2;
  // Reset values
  localparam logic [1:0] RST_MODE = MODE_PULSED;
  localparam logic [DEG_W-1:0] RST_AMBIENT = 8'h14;
  localparam logic [DEG_W-1:0] RST_ALARM = 8'h50;
  localparam logic [DEG_W-1:0] RST_TRIP = 8'h64;
  localparam logic [DEG_W-1:0] RST_UNLOCK = 8'h3c;
  localparam logic [CUR_W-1:0] RST_RATED_CUR = 16'h1000;
  localparam logic [DEG_W-1:0] RST_RATED_TEMP = 8'h64;
  localparam logic [DEG_W-1:0] RST_BASE_TEMP = 8'h28;
  localparam logic [TC_W-1:0] RST_TIME_CONST = 24'h0927c0;
  localparam logic [DEG_W-1:0] RST_STARTUP = 8'h00;
  localparam logic [5:0] DIV_STEPS = 6'h20;

  typedef struct packed {
    logic [CUR_W-1:0] phase_a;
    logic [CUR_W-1:0] phase_b;
    logic [CUR_W-1:0] phase_c;
  } ltr_rms_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } ltr_apb_req_t;
endpackage
`default_nettype wire

/* File: verilog/ltr_divider.sv */
`default_nettype none
module ltr_divider (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [31:0] num,
  input wire logic [ltr_pkg::TC_W-1:0] den,
  output logic done,
  output logic [31:0] quot
);
  import ltr_pkg::*;

  logic [TC_W:0] rem_reg, rem_next;
  logic [31:0] quo_reg, quo_next;
  logic [5:0] cnt_reg, cnt_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;

  ////////////////////////////////////////////////////////////////////////////
  // Restoring division, one quotient bit a cycle; zero divisor gives ones
  always_comb begin
    logic [TC_W:0] trial;
    logic q_bit;
    trial = {rem_reg[TC_W-1:0], quo_reg[31]};
    q_bit = 1'b0;
    rem_next = rem_reg;
    quo_next = quo_reg;
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (start) begin
      rem_next = '0;
      quo_next = num;
      cnt_next = DIV_STEPS;
      busy_next = 1'b1;
    end else if (busy_reg) begin
      if (trial >= {1'b0, den}) begin
        rem_next = trial - {1'b0, den};
        q_bit = 1'b1;
      end else begin
        rem_next = trial;
      end
      quo_next = {quo_reg[30:0], q_bit};
      cnt_next = cnt_reg - 6'h01;
      if (cnt_reg == 6'h01) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem_reg <= '0;
      quo_reg <= '0;
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      rem_reg <= rem_next;
      quo_reg <= quo_next;
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;
  assign quot = quo_reg;
endmodule // ltr_divider
`default_nettype wire

/* File: verilog/ltr_thermal.sv */
`default_nettype none
module ltr_thermal (
  input wire logic pclk,
  input wire logic presetn,
  input wire ltr_pkg::ltr_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ltr_pkg::ltr_rms_t rms_in,
  input wire logic sample_tick,
  input wire logic [ltr_pkg::DEG_W-1:0] ambient_sensor,
  output logic alarm_out,
  output logic trip_out,
  output logic [ltr_pkg::TEMP_W-1:0] temperature_out
);
  import ltr_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_LOAD, ST_RATIO, ST_STEP, ST_DECIDE
  } ltr_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [1:0] mode_reg, mode_next;
  logic sens_sel_reg, sens_sel_next;
  logic [DEG_W-1:0] ambient_reg, ambient_next;
  logic [DEG_W-1:0] alarm_thr_reg, alarm_thr_next;
  logic [DEG_W-1:0] trip_thr_reg, trip_thr_next;
  logic [DEG_W-1:0] unlock_thr_reg, unlock_thr_next;
  logic [CUR_W-1:0] rated_cur_reg, rated_cur_next;
  logic [DEG_W-1:0] rated_temp_reg, rated_temp_next;
  logic [DEG_W-1:0] base_temp_reg, base_temp_next;
  logic [TC_W-1:0] time_const_reg, time_const_next;
  logic [DEG_W-1:0] startup_reg, startup_next;
  logic load_req;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;

  ltr_state_t state_reg, state_next;
  logic load_pend_reg, load_pend_next;
  logic [LVL_W-1:0] level_reg, level_next;
  logic [LVL_W-1:0] ratio_reg, ratio_next;
  logic up_reg, up_next;
  logic div_start_reg, div_start_next;
  logic [31:0] div_num_reg, div_num_next;
  logic [TC_W-1:0] div_den_reg, div_den_next;
  logic above_prev_reg, above_prev_next;
  logic alarm_reg, alarm_next;
  logic trip_reg, trip_next;
  logic [TEMP_W-1:0] temp_reg, temp_next;
  logic div_done;
  logic [31:0] div_quot;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: decode in setup, answer with pready in the access cycle
  always_comb begin
    logic setup;
    logic wr;
    logic hit;
    logic [31:0] rd;
    setup = apb_req.psel & ~apb_req.penable;
    wr = apb_req.psel & apb_req.penable & pready_reg & apb_req.pwrite;
    hit = 1'b1;
    rd = '0;
    mode_next = mode_reg;
    sens_sel_next = sens_sel_reg;
    ambient_next = ambient_reg;
    alarm_thr_next = alarm_thr_reg;
    trip_thr_next = trip_thr_reg;
    unlock_thr_next = unlock_thr_reg;
    rated_cur_next = rated_cur_reg;
    rated_temp_next = rated_temp_reg;
    base_temp_next = base_temp_reg;
    time_const_next = time_const_reg;
    startup_next = startup_reg;
    load_req = 1'b0;
    case (apb_req.paddr)
      OFS_CTRL: begin
        rd[CTRL_MODE_LSB +: 2] = mode_reg;
        rd[CTRL_SENS_BIT] = sens_sel_reg;
        if (wr) begin
          mode_next = apb_req.pwdata[CTRL_MODE_LSB +: 2];
          sens_sel_next = apb_req.pwdata[CTRL_SENS_BIT];
          load_req = apb_req.pwdata[CTRL_LOAD_BIT];
        end
      end
      OFS_AMBIENT: begin
        rd[DEG_W-1:0] = ambient_reg;
        if (wr) ambient_next = apb_req.pwdata[DEG_W-1:0];
      end
      OFS_ALARM: begin
        rd[DEG_W-1:0] = alarm_thr_reg;
        if (wr) alarm_thr_next = apb_req.pwdata[DEG_W-1:0];
      end
      OFS_TRIP: begin
        rd[DEG_W-1:0] = trip_thr_reg;
        if (wr) trip_thr_next = apb_req.pwdata[DEG_W-1:0];
      end
      OFS_UNLOCK: begin
        rd[DEG_W-1:0] = unlock_thr_reg;
        if (wr) unlock_thr_next = apb_req.pwdata[DEG_W-1:0];
      end
      OFS_RATED_CUR: begin
        rd[CUR_W-1:0] = rated_cur_reg;
        if (wr) rated_cur_next = apb_req.pwdata[CUR_W-1:0];
      end
      OFS_RATED_TEMP: begin
        rd[DEG_W-1:0] = rated_temp_reg;
        if (wr) rated_temp_next = apb_req.pwdata[DEG_W-1:0];
      end
      OFS_BASE_TEMP: begin
        rd[DEG_W-1:0] = base_temp_reg;
        if (wr) base_temp_next = apb_req.pwdata[DEG_W-1:0];
      end
      OFS_TIME_CONST: begin
        rd[TC_W-1:0] = time_const_reg;
        if (wr) time_const_next = apb_req.pwdata[TC_W-1:0];
      end
      OFS_STARTUP: begin
        rd[DEG_W-1:0] = startup_reg;
        if (wr) startup_next = apb_req.pwdata[DEG_W-1:0];
      end
      OFS_STATUS: begin
        rd[STAT_BUSY_BIT] = (state_reg != ST_IDLE);
        rd[STAT_ALARM_BIT] = alarm_reg;
        rd[STAT_TRIP_BIT] = trip_reg;
        rd[STAT_TEMP_LSB +: TEMP_W] = temp_reg;
      end
      OFS_LEVEL: rd = level_reg;
      default: hit = 1'b0;
    endcase
    pready_next = setup;
    pslverr_next = setup & ~hit;
    prdata_next = setup ? rd : prdata_reg;
  end

  // Configuration and bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= RST_MODE;
      sens_sel_reg <= 1'b0;
      ambient_reg <= RST_AMBIENT;
      alarm_thr_reg <= RST_ALARM;
      trip_thr_reg <= RST_TRIP;
      unlock_thr_reg <= RST_UNLOCK;
      rated_cur_reg <= RST_RATED_CUR;
      rated_temp_reg <= RST_RATED_TEMP;
      base_temp_reg <= RST_BASE_TEMP;
      time_const_reg <= RST_TIME_CONST;
      startup_reg <= RST_STARTUP;
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      sens_sel_reg <= sens_sel_next;
      ambient_reg <= ambient_next;
      alarm_thr_reg <= alarm_thr_next;
      trip_thr_reg <= trip_thr_next;
      unlock_thr_reg <= unlock_thr_next;
      rated_cur_reg <= rated_cur_next;
      rated_temp_reg <= rated_temp_next;
      base_temp_reg <= base_temp_next;
      time_const_reg <= time_const_next;
      startup_reg <= startup_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared sequential divider for startup, ratio and step
  ltr_divider u_div (
    .pclk(pclk),
    .presetn(presetn),
    .start(div_start_reg),
    .num(div_num_reg),
    .den(div_den_reg),
    .done(div_done),
    .quot(div_quot)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Thermal model sequence and decision
  always_comb begin
    logic [CUR_W-1:0] imax;
    logic [CUR_W-1:0] q;
    logic [LVL_W-1:0] ratio;
    logic [DEG_W-1:0] rise_n;
    logic [39:0] prod;
    logic [TEMP_W-1:0] rise;
    logic [DEG_W-1:0] amb;
    logic [TEMP_W:0] sum;
    logic [TEMP_W-1:0] total;
    logic above;
    imax = rms_in.phase_a;
    if (rms_in.phase_b > imax) imax = rms_in.phase_b;
    if (rms_in.phase_c > imax) imax = rms_in.phase_c;
    q = (div_quot[31:CUR_W] != '0) ? '1 : div_quot[CUR_W-1:0];
    ratio = LVL_W'(q) * LVL_W'(q);
    rise_n = (rated_temp_reg > base_temp_reg) ?
             (rated_temp_reg - base_temp_reg) : '0;
    prod = 40'(level_reg) * 40'(rise_n);
    rise = (prod[39:32] != '0) ? '1 : prod[31:QFRAC];
    amb = sens_sel_reg ? ambient_sensor : ambient_reg;
    sum = (TEMP_W+1)'(rise) + (TEMP_W+1)'(amb);
    total = sum[TEMP_W] ? '1 : sum[TEMP_W-1:0];
    above = total > TEMP_W'(trip_thr_reg);
    state_next = state_reg;
    load_pend_next = load_pend_reg | load_req;
    level_next = level_reg;
    ratio_next = ratio_reg;
    up_next = up_reg;
    div_start_next = 1'b0;
    div_num_next = div_num_reg;
    div_den_next = div_den_reg;
    above_prev_next = above_prev_reg;
    alarm_next = alarm_reg;
    trip_next = (mode_reg == MODE_LOCKED) ? trip_reg : 1'b0;
    temp_next = temp_reg;
    case (state_reg)
      ST_IDLE: begin
        if (load_pend_reg) begin
          // Startup percentage to Q16.16 level
          load_pend_next = load_req;
          div_num_next = {8'h00, startup_reg, 16'h0000};
          div_den_next = TC_W'(PCT_FULL);
          div_start_next = 1'b1;
          state_next = ST_LOAD;
        end else if (sample_tick) begin
          // Current ratio in Q8.8 from the largest phase
          div_num_next = {8'h00, imax, 8'h00};
          div_den_next = TC_W'(rated_cur_reg);
          div_start_next = 1'b1;
          state_next = ST_RATIO;
        end
      end
      ST_LOAD: begin
        if (div_done) begin
          level_next = div_quot;
          state_next = ST_DECIDE;
        end
      end
      ST_RATIO: begin
        if (div_done) begin
          ratio_next = ratio;
          up_next = ratio >= level_reg;
          div_num_next = (ratio >= level_reg) ? (ratio - level_reg) :
                         (level_reg - ratio);
          div_den_next = time_const_reg;
          div_start_next = 1'b1;
          state_next = ST_STEP;
        end
      end
      ST_STEP: begin
        if (div_done) begin
          // Move toward the squared ratio by diff/T, never past it
          if (div_quot >= (up_reg ? (ratio_reg - level_reg) :
                                    (level_reg - ratio_reg))) begin
            level_next = ratio_reg;
          end else begin
            level_next = up_reg ? (level_reg + div_quot) :
                         (level_reg - div_quot);
          end
          state_next = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        temp_next = total;
        above_prev_next = above;
        alarm_next = total > TEMP_W'(alarm_thr_reg);
        case (mode_reg)
          MODE_PULSED: trip_next = above & ~above_prev_reg;
          MODE_LOCKED: begin
            if (above) trip_next = 1'b1;
            else if (total < TEMP_W'(unlock_thr_reg)) trip_next = 1'b0;
            else trip_next = trip_reg;
          end
          default: trip_next = 1'b0;
        endcase
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    if (mode_reg == MODE_OFF) begin
      alarm_next = 1'b0;
      trip_next = 1'b0;
    end
  end

  // Model state registers; reset requests a startup load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      load_pend_reg <= 1'b1;
      level_reg <= '0;
      ratio_reg <= '0;
      up_reg <= 1'b0;
      div_start_reg <= 1'b0;
      div_num_reg <= '0;
      div_den_reg <= '0;
      above_prev_reg <= 1'b0;
      alarm_reg <= 1'b0;
      trip_reg <= 1'b0;
      temp_reg <= '0;
    end else begin
      state_reg <= state_next;
      load_pend_reg <= load_pend_next;
      level_reg <= level_next;
      ratio_reg <= ratio_next;
      up_reg <= up_next;
      div_start_reg <= div_start_next;
      div_num_reg <= div_num_next;
      div_den_reg <= div_den_next;
      above_prev_reg <= above_prev_next;
      alarm_reg <= alarm_next;
      trip_reg <= trip_next;
      temp_reg <= temp_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign alarm_out = alarm_reg;
  assign trip_out = trip_reg;
  assign temperature_out = temp_reg;
endmodule // ltr_thermal
`default_nettype wire

/* File: sim/ltr_rms_source.sv */
`default_nettype none
module ltr_rms_source (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fire,
  input wire ltr_pkg::ltr_rms_t value,
  output ltr_pkg::ltr_rms_t rms_in,
  output logic sample_tick
);
  timeunit 1ns;
  timeprecision 100ps;
  import ltr_pkg::*;
  // One tick per sample; values are only good in the tick cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_tick <= 1'b0;
      rms_in <= '0;
    end else begin
      sample_tick <= fire;
      rms_in <= fire ? value : ~rms_in;
    end
  end
endmodule // ltr_rms_source
`default_nettype wire

/* File: sim/ltr_thermal_checker.sv */
`default_nettype none
module ltr_thermal_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire ltr_pkg::ltr_apb_req_t apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire ltr_pkg::ltr_rms_t rms_in,
  input wire logic sample_tick,
  input wire logic [ltr_pkg::DEG_W-1:0] ambient_sensor,
  input wire logic alarm_out,
  input wire logic trip_out,
  input wire logic [ltr_pkg::TEMP_W-1:0] temperature_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import ltr_pkg::*;
  logic wr;
  logic [1:0] mode_reg, mode_next;
  logic [7:0] alm_reg, alm_next, trp_reg, trp_next;
  logic [7:0] unl_reg, unl_next, age_reg, age_next;
  assign wr = apb_req.psel & apb_req.penable & pready & apb_req.pwrite;
  // Shadow settings and cycles since the last model trigger
  always_comb begin
    mode_next = mode_reg;
    alm_next = alm_reg;
    trp_next = trp_reg;
    unl_next = unl_reg;
    age_next = (age_reg == 8'hff) ? age_reg : age_reg + 8'h01;
    if (sample_tick) age_next = 8'h00;
    if (wr && apb_req.paddr == OFS_CTRL) begin
      mode_next = apb_req.pwdata[1:0];
      if (apb_req.pwdata[CTRL_LOAD_BIT]) age_next = 8'h00;
    end
    if (wr && apb_req.paddr == OFS_ALARM) alm_next = apb_req.pwdata[7:0];
    if (wr && apb_req.paddr == OFS_TRIP) trp_next = apb_req.pwdata[7:0];
    if (wr && apb_req.paddr == OFS_UNLOCK) unl_next = apb_req.pwdata[7:0];
  end
  // Shadow registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= RST_MODE;
      alm_reg <= RST_ALARM;
      trp_reg <= RST_TRIP;
      unl_reg <= RST_UNLOCK;
      age_reg <= 8'h00;
    end else begin
      mode_reg <= mode_next;
      alm_reg <= alm_next;
      trp_reg <= trp_next;
      unl_reg <= unl_next;
      age_reg <= age_next;
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_APB_ANSWER: assert property (
    apb_req.psel && !apb_req.penable |=> pready)
    else $error("no ready after setup");
  AST_APB_ONE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_APB_ERR: assert property (
    pslverr |-> pready && prdata == 32'h0)
    else $error("bad error response");
  AST_ALARM: assert property ($changed(temperature_out) |->
    alarm_out == (mode_reg != MODE_OFF && temperature_out > alm_reg))
    else $error("alarm does not follow temperature");
  AST_OFF_QUIET: assert property (
    mode_reg == MODE_OFF && $changed(temperature_out) |-> !trip_out)
    else $error("trip in off mode");
  AST_PULSE: assert property (
    mode_reg == MODE_PULSED && trip_out |=> !trip_out)
    else $error("trip pulse too long");
  AST_TRIP_CAUSE: assert property (
    $rose(trip_out) |-> temperature_out > trp_reg)
    else $error("trip without temperature above threshold");
  AST_LOCK_SET: assert property (mode_reg == MODE_LOCKED &&
    $changed(temperature_out) && temperature_out > trp_reg |-> trip_out)
    else $error("locked trip not set");
  AST_LOCK_HOLD: assert property (
    mode_reg == MODE_LOCKED && $fell(trip_out) |-> temperature_out < unl_reg)
    else $error("locked trip released above unlock");
  AST_TICK_PACE: assert property (
    $changed(temperature_out) |-> age_reg < 8'h5a)
    else $error("temperature changed without a tick");
endmodule // ltr_thermal_checker
bind ltr_thermal ltr_thermal_checker u_checker (.pclk(pclk),
  .presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rms_in(rms_in), .sample_tick(sample_tick),
  .ambient_sensor(ambient_sensor), .alarm_out(alarm_out),
  .trip_out(trip_out), .temperature_out(temperature_out));
`default_nettype wire

/* File: sim/ltr_thermal_tb.sv */
`default_nettype none
module ltr_thermal_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ltr_pkg::*;
  logic pclk, presetn, pready, pslverr, sample_tick, alarm_out, trip_out;
  logic fire;
  ltr_apb_req_t apb_req;
  ltr_rms_t rms_in, phase;
  logic [31:0] prdata;
  logic [7:0] ambient_sensor, amb = 8'h14, alm = 8'h50;
  logic [7:0] rtemp = 8'h64, btemp = 8'h28;
  logic [15:0] temperature_out, exp_t, irat = 16'h1000, lfsr = 16'h0042;
  logic [1:0] mode = MODE_PULSED;
  longint unsigned exp_lvl = 0, tc = 600000;
  int bad_count, n_compared, pulses;
  logic [7:0] rofs [10] = '{OFS_CTRL, OFS_AMBIENT, OFS_ALARM, OFS_TRIP,
    OFS_UNLOCK, OFS_RATED_CUR, OFS_RATED_TEMP, OFS_BASE_TEMP,
    OFS_TIME_CONST, OFS_STARTUP};
  logic [31:0] rval [10] = '{32'h1, 32'h14, 32'h50, 32'h64, 32'h3c,
    32'h1000, 32'h64, 32'h28, 32'h927c0, 32'h0};
  ltr_thermal u_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rms_in(rms_in),
    .sample_tick(sample_tick), .ambient_sensor(ambient_sensor),
    .alarm_out(alarm_out), .trip_out(trip_out),
    .temperature_out(temperature_out));
  ltr_rms_source u_src (.pclk(pclk), .presetn(presetn), .fire(fire),
    .value(phase), .rms_in(rms_in), .sample_tick(sample_tick));
  ////////////////////////////////////////////////////////////
  // Clock and trip pulse counter
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) if (trip_out === 1'b1) pulses <= pulses + 1;
  // Random source
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr & 16'h1fff;
  endfunction
  // Expected squared current ratio, step and temperature
  function automatic longint unsigned sq(input logic [15:0] m);
    longint unsigned q;
    q = (irat == 16'h0) ? 64'hffff : {m, 8'h00} / irat;
    if (q > 64'hffff) q = 64'hffff;
    return q * q;
  endfunction
  function automatic longint unsigned step(input longint unsigned l,
      input longint unsigned r);
    return (r >= l) ? l + (r - l) / tc : l - (l - r) / tc;
  endfunction
  function automatic logic [15:0] exp_temp(input longint unsigned l);
    longint unsigned t;
    t = (l * (rtemp - btemp)) >> 16;
    t = (t > 64'hffff) ? 64'hffff : t;
    t = t + amb;
    return (t > 64'hffff) ? 16'hffff : t[15:0];
  endfunction
  // Comparison and verdict
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Bus transfers
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) bad_count++;
    q = prdata;
    e = pslverr;
    apb_req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x,
      input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    check("read_data", q, x);
    check("read_err", e, xe);
  endtask
  task automatic idle();
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      rd(OFS_STATUS, q);
      n++;
    end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 40);
    if (q[STAT_BUSY_BIT] !== 1'b0) bad_count++;
    repeat (4) @(posedge pclk);
  endtask
  // One sample through the front end, then the decision
  task automatic tick(input logic [15:0] a, input logic [15:0] b,
      input logic [15:0] c);
    logic [15:0] m;
    m = (a > b) ? a : b;
    m = (c > m) ? c : m;
    @(posedge pclk);
    phase <= '{a, b, c};
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    exp_lvl = step(exp_lvl, sq(m));
    exp_t = exp_temp(exp_lvl);
    repeat (80) @(posedge pclk);
    check("temperature", temperature_out, exp_t);
    check("alarm", alarm_out, mode != MODE_OFF && exp_t > alm);
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] q;
    apb_req = '0;
    fire = 1'b0;
    phase = '0;
    ambient_sensor = 8'h00;
    presetn = 1'b0;
    bad_count = 0;
    n_compared = 0;
    pulses = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++) rdc(rofs[i], rval[i], 1'b0);
    rdc(8'h30, 32'h0, 1'b1);
    idle();
    rd(OFS_STATUS, q);
    check("reset_temp", q[31:16], 16'h14);
    // Startup reload at half the rated rise
    wr(OFS_TIME_CONST, 32'h1);
    tc = 1;
    wr(OFS_STARTUP, 32'h32);
    wr(OFS_CTRL, 32'h9);
    idle();
    exp_lvl = 64'h8000;
    rd(OFS_LEVEL, q);
    check("start_level", q, 32'h8000);
    rd(OFS_STATUS, q);
    check("start_temp", q[31:16], 16'h32);
    // Random phase currents, then measured ambient
    repeat (8) tick(rnd(), rnd(), rnd());
    ambient_sensor <= lfsr[7:0];
    amb = lfsr[7:0];
    wr(OFS_CTRL, 32'h5);
    repeat (2) tick(rnd(), rnd(), rnd());
    wr(OFS_CTRL, 32'h1);
    amb = 8'h14;
    tick(rnd(), rnd(), rnd());
    // Gradual heating and cooling, then an oversized current
    wr(OFS_TIME_CONST, 32'h4);
    tc = 4;
    repeat (4) tick(16'h1400, 16'h0, 16'h0);
    repeat (2) tick(16'h0, 16'h0, 16'h0);
    wr(OFS_RATED_CUR, 32'h10);
    irat = 16'h10;
    tick(16'hffff, 16'hffff, 16'h0);
    wr(OFS_RATED_CUR, 32'h1000);
    irat = 16'h1000;
    wr(OFS_TIME_CONST, 32'h1);
    tc = 1;
    // Locked trip holds until below unlock
    wr(OFS_CTRL, 32'h2);
    mode = MODE_LOCKED;
    tick(16'h1400, 16'h0, 16'h0);
    check("trip_set", trip_out, 1'b1);
    tick(16'h0, 16'h1000, 16'h0);
    check("trip_hold", trip_out, 1'b1);
    tick(16'h0, 16'h0, 16'h0);
    check("trip_free", trip_out, 1'b0);
    // Pulsed trip on each new crossing, none when off
    wr(OFS_CTRL, 32'h1);
    mode = MODE_PULSED;
    pulses = 0;
    repeat (2) tick(16'h0, 16'h0, 16'h1400);
    tick(16'h0, 16'h0, 16'h0);
    tick(16'h1400, 16'h0, 16'h0);
    check("pulses", pulses, 32'h2);
    wr(OFS_CTRL, 32'h0);
    mode = MODE_OFF;
    tick(16'h0, 16'h0, 16'h0);
    tick(16'h1400, 16'h0, 16'h0);
    check("trip_off", trip_out, 1'b0);
    test_done();
  end
  // Watchdog
  initial begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    test_done();
  end
endmodule // ltr_thermal_tb
`default_nettype wire
